/* rtl/srs_seq.sv */
// Reset and clock sequencer with APB register access
`timescale 1ns/1ps
`include "srs_map.svh"

module srs_seq
(
    input  logic                CORE_CLK,
    input  logic                RSTN,
    input  logic                PSEL,
    input  logic                PENABLE,
    input  logic                PWRITE,
    input  logic [7:0]          PADDR,
    input  logic [31:0]         PWDATA,
    output logic [31:0]         PRDATA,
    output logic                PREADY,
    output logic                PSLVERR,
    input  srs_pkg::srs_cpu_t   CPU_EVT,
    input  logic                WAKE_IRQ,
    input  logic                POR_PULSE,
    input  logic                LOW_SUPPLY_DET,
    input  logic                RST_PIN_N,
    input  logic                WDG_RESET_IN,
    input  logic                IRQ_HV,
    input  logic                MONITOR_MODE,
    output logic                CPU_CLK_EN,
    output logic                PERIPH_CLK_EN,
    output logic                INTERNAL_RESET_N,
    output logic [15:0]         VECTOR_ADDR,
    output logic                MONITOR_FORCED,
    output logic                WDG_CLK_PULSE
);

    srs_pkg::srs_regs_t s_q;
    srs_pkg::srs_regs_t s_d;

    logic        bus_tick;
    logic        wdg_off;
    logic        run_st;
    logic        in_stop;
    logic        por_ev;
    logic        low_ev;
    logic        pin_low;
    logic        wdg_ev;
    logic        bad_op_ev;
    logic        bad_adr_ev;
    logic        blank_ev;
    logic        soft_ev;
    logic        apb_acc;
    logic        apb_hit;
    logic [11:0] rec_last;

    // Next state of the whole sequencer
    always_comb
    begin
        s_d = s_q;
        apb_hit = 1'b0;

        // Two-stage synchronisers; pin stored inverted so reset means high
        s_d.pin_s1 = ~RST_PIN_N;
        s_d.pin_s2 = s_q.pin_s1;
        s_d.wd_s1  = WDG_RESET_IN;
        s_d.wd_s2  = s_q.wd_s1;

        // Divide-by-four enable for the bus clocks
        s_d.div  = s_q.div + 2'h1;
        bus_tick = (s_q.div == `SRS_DIV_LAST);

        // Gating and event decode
        wdg_off = IRQ_HV & MONITOR_MODE;
        run_st  = (s_q.st == srs_pkg::ST_RUN);
        in_stop = (s_q.st == srs_pkg::ST_STOP) |
                  (s_q.st == srs_pkg::ST_STOPREC);
        por_ev  = POR_PULSE;
        low_ev  = LOW_SUPPLY_DET &
                  ~s_q.cfg[`SRS_CFG_PWR_DIS] &
                  ~s_q.cfg[`SRS_CFG_RST_DIS];
        pin_low = s_q.pin_s2;
        wdg_ev  = ~wdg_off & (s_q.wd_s2 |
                  (s_q.wdg_tick &
                   (s_q.wdg == `SRS_WDG_LAST)));
        bad_op_ev = run_st & (CPU_EVT.illegal_op |
                    (CPU_EVT.stop_exec &
                     ~s_q.cfg[`SRS_CFG_STOP_EN]));
        bad_adr_ev = run_st & CPU_EVT.opc_fetch &
                     CPU_EVT.addr_unmapped;
        blank_ev = run_st & CPU_EVT.vec_fetch &
                   (CPU_EVT.data == `SRS_ERASED);
        soft_ev = wdg_ev | bad_op_ev | bad_adr_ev | blank_ev;
        rec_last = s_q.cfg[`SRS_CFG_SHORT_REC] ?
                   `SRS_SHORT_LAST : `SRS_LONG_LAST;

        // Watchdog counter advances on each counter overflow unless the watchdog is gated off
        if (s_q.wdg_tick && !wdg_off)
        begin
            s_d.wdg = s_q.wdg + 8'h01;
        end

        // APB access phase: answer one cycle after it opens
        apb_acc   = PSEL & PENABLE & ~s_q.pready;
        s_d.pready  = apb_acc;
        s_d.pslverr = 1'b0;
        if (apb_acc)
        begin
            s_d.prdata = 32'h0000_0000;
            case (PADDR)
                `SRS_OFF_CAUSE:
                begin
                    apb_hit = 1'b1;
                    if (!PWRITE)
                    begin
                        s_d.prdata = {24'h00_0000, s_q.cause};
                        s_d.cause  = 8'h00;           // Read clears
                    end
                end
                `SRS_OFF_CONFIG:
                begin
                    apb_hit = 1'b1;
                    if (PWRITE)
                    begin
                        s_d.cfg = PWDATA[3:0];
                    end
                    else
                    begin
                        s_d.prdata = {28'h000_0000, s_q.cfg};
                    end
                end
                `SRS_OFF_STATUS:
                begin
                    apb_hit = 1'b1;
                    s_d.prdata = {8'h00, s_q.wdg, s_q.cnt,
                                  1'b0, s_q.st};
                end
                default:
                begin
                    apb_hit = 1'b0;
                end
            endcase
            s_d.pslverr = ~apb_hit;
        end

        // Reset sources by priority, then normal sequencing
        if (por_ev)
        begin
            s_d.cause = 8'h01 << `SRS_C_POR;
            s_d.st    = srs_pkg::ST_LONG;
            s_d.cnt   = 12'h000;
            s_d.wdg   = 8'h00;
            s_d.cfg   = `SRS_CFG_RESET;
            s_d.forced_mon = 1'b0;
            s_d.stop_rst   = 1'b0;
        end
        else if (low_ev)
        begin
            s_d.cause[`SRS_C_LOW_SUP] = 1'b1;
            s_d.st  = srs_pkg::ST_HOLD;
            s_d.cnt = 12'h000;
            s_d.wdg = 8'h00;
            s_d.cfg = `SRS_CFG_RESET;
            s_d.stop_rst = 1'b0;
        end
        else if (pin_low)
        begin
            s_d.st  = srs_pkg::ST_PIN;
            s_d.cnt = 12'h000;
            s_d.wdg = 8'h00;
            s_d.cfg = `SRS_CFG_RESET;
            if (in_stop)
            begin
                s_d.stop_rst = 1'b1;
            end
            if (s_q.pin_cnt != `SRS_PIN_MIN)
            begin
                s_d.pin_cnt = s_q.pin_cnt + 4'h1;
            end
            else
            begin
                s_d.cause[`SRS_C_PIN] = 1'b1;
            end
        end
        else if (soft_ev)
        begin
            // Set wins over a read clear in the same cycle
            if (wdg_ev)
            begin
                s_d.cause[`SRS_C_WDG] = 1'b1;
            end
            if (bad_op_ev)
            begin
                s_d.cause[`SRS_C_BAD_OP] = 1'b1;
            end
            if (bad_adr_ev)
            begin
                s_d.cause[`SRS_C_BAD_ADDR] = 1'b1;
            end
            if (blank_ev)
            begin
                s_d.cause[`SRS_C_BLANK] = 1'b1;
                s_d.forced_mon = 1'b1;
            end
            s_d.cnt = 12'h000;
            s_d.wdg = 8'h00;
            s_d.cfg = `SRS_CFG_RESET;
            s_d.stop_rst = 1'b0;
            s_d.st  = in_stop ? srs_pkg::ST_LONG :
                                srs_pkg::ST_PHASE;
        end
        else
        begin
            s_d.pin_cnt = 4'h0;
            case (s_q.st)
                srs_pkg::ST_LONG:
                begin
                    s_d.cnt = s_q.cnt + 12'h001;
                    if (s_q.cnt == `SRS_LONG_LAST)
                    begin
                        s_d.st  = srs_pkg::ST_PHASE;
                        s_d.cnt = 12'h000;
                        s_d.stop_rst = 1'b0;
                    end
                end
                srs_pkg::ST_HOLD:
                begin
                    s_d.st  = srs_pkg::ST_LONG;
                    s_d.cnt = 12'h000;
                end
                srs_pkg::ST_PHASE:
                begin
                    s_d.cnt = s_q.cnt + 12'h001;
                    if (s_q.cnt == `SRS_PHASE_LAST)
                    begin
                        s_d.st = srs_pkg::ST_RUN;
                    end
                end
                srs_pkg::ST_PIN:
                begin
                    s_d.cnt = 12'h000;
                    s_d.st  = s_q.stop_rst ?
                              srs_pkg::ST_LONG :
                              srs_pkg::ST_PHASE;
                end
                srs_pkg::ST_RUN:
                begin
                    s_d.cnt = s_q.cnt + 12'h001;
                    if (CPU_EVT.wr_stb &&
                        CPU_EVT.addr == `SRS_SERVICE_ADDR)
                    begin
                        s_d.wdg = 8'h00;
                        s_d.cnt[11:4] = 8'h00;
                    end
                    if (CPU_EVT.stop_exec)
                    begin
                        s_d.st  = srs_pkg::ST_STOP;
                        s_d.cnt = 12'h000;
                    end
                    else if (CPU_EVT.wait_exec)
                    begin
                        s_d.st = srs_pkg::ST_WAIT;
                    end
                end
                srs_pkg::ST_WAIT:
                begin
                    s_d.cnt = s_q.cnt + 12'h001;
                    if (WAKE_IRQ)
                    begin
                        s_d.st = srs_pkg::ST_RUN;
                    end
                end
                srs_pkg::ST_STOP:
                begin
                    s_d.cnt = 12'h000;
                    if (WAKE_IRQ)
                    begin
                        s_d.st = srs_pkg::ST_STOPREC;
                    end
                end
                srs_pkg::ST_STOPREC:
                begin
                    s_d.cnt = s_q.cnt + 12'h001;
                    if (s_q.cnt == rec_last)
                    begin
                        s_d.st = srs_pkg::ST_RUN;
                    end
                end
                default:
                begin
                    s_d.st = srs_pkg::ST_LONG;
                end
            endcase
        end

        // Registered outputs derived from the next state, except the watchdog tick, which comes from the present state
        s_d.wdg_tick = (s_q.cnt == `SRS_LONG_LAST) &
                       (run_st |
                        (s_q.st == srs_pkg::ST_WAIT));
        s_d.released = (s_d.st == srs_pkg::ST_RUN) |
                       (s_d.st == srs_pkg::ST_WAIT) |
                       (s_d.st == srs_pkg::ST_STOP) |
                       (s_d.st == srs_pkg::ST_STOPREC);
        s_d.cpu_en = bus_tick &
                     ((s_d.st == srs_pkg::ST_RUN) |
                      (s_d.st == srs_pkg::ST_PHASE));
        s_d.per_en = bus_tick &
                     ((s_d.st == srs_pkg::ST_RUN) |
                      (s_d.st == srs_pkg::ST_WAIT) |
                      (s_d.st == srs_pkg::ST_PHASE));
        s_d.vec = s_d.forced_mon ? `SRS_VEC_MON :
                                   `SRS_VEC_USER;
    end

    // State register; reset starts the power-on hold
    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign PRDATA           = s_q.prdata;
    assign PREADY           = s_q.pready;
    assign PSLVERR          = s_q.pslverr;
    assign CPU_CLK_EN       = s_q.cpu_en;
    assign PERIPH_CLK_EN    = s_q.per_en;
    assign INTERNAL_RESET_N = s_q.released;
    assign VECTOR_ADDR      = s_q.vec;
    assign MONITOR_FORCED   = s_q.forced_mon;
    assign WDG_CLK_PULSE    = s_q.wdg_tick;

    // Helper count of cycles spent in the 64-cycle phase
    logic [6:0] ph_len_q;
    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            ph_len_q <= 7'h00;
        end
        else
        begin
            ph_len_q <= (s_q.st == srs_pkg::ST_PHASE) ?
                        ph_len_q + 7'h01 : 7'h00;
        end
    end

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RSTN);

    // Step sequences for stop recovery
    sequence rec_enter;
        $rose(s_q.st == srs_pkg::ST_STOPREC) &&
        s_q.cfg[`SRS_CFG_SHORT_REC];
    endsequence
    sequence rec_done;
        ##31 (s_q.st == srs_pkg::ST_STOPREC)
        ##1 (s_q.st != srs_pkg::ST_STOPREC);
    endsequence

    // Bus clock enable never closer than four cycles
    a_bus_quarter: assert property (
        PERIPH_CLK_EN |=> !PERIPH_CLK_EN [*3])
        else $error("bus enable faster than one in four");

    // Long hold keeps reset and clocks off
    a_long_hold: assert property (
        (s_q.st == srs_pkg::ST_LONG) |->
        !INTERNAL_RESET_N && !CPU_CLK_EN && !PERIPH_CLK_EN)
        else $error("clocks or release during long hold");

    // Reset phase lasts exactly 64 cycles
    a_phase_len: assert property (
        (s_q.st == srs_pkg::ST_RUN &&
         $past(s_q.st) == srs_pkg::ST_PHASE) |->
        ph_len_q == `SRS_PHASE_LEN && INTERNAL_RESET_N)
        else $error("reset phase length wrong");

    // No clocks in stop, no CPU clock in wait
    a_stop_clocks: assert property (
        (s_q.st == srs_pkg::ST_STOP ||
         s_q.st == srs_pkg::ST_WAIT) |-> !CPU_CLK_EN &&
        (s_q.st == srs_pkg::ST_WAIT || !PERIPH_CLK_EN))
        else $error("clock enable in low power state");

    // Power-on leaves only its own cause bit
    a_por_cause: assert property (
        POR_PULSE |=> s_q.cause == (8'h01 << `SRS_C_POR) &&
        !INTERNAL_RESET_N)
        else $error("power-on cause not exclusive");

    // Disabled stop becomes a bad-opcode reset
    a_stop_bad_op: assert property (
        (run_st && CPU_EVT.stop_exec && !POR_PULSE &&
         !low_ev && !pin_low &&
         !s_q.cfg[`SRS_CFG_STOP_EN]) |=>
        s_q.cause[`SRS_C_BAD_OP] &&
        s_q.st == srs_pkg::ST_PHASE)
        else $error("disabled stop did not reset");

    // Unmapped data fetch is harmless
    a_data_fetch: assert property (
        (run_st && CPU_EVT.addr_unmapped && !CPU_EVT.opc_fetch &&
         !CPU_EVT.illegal_op && !CPU_EVT.stop_exec &&
         !CPU_EVT.vec_fetch && !wdg_ev && !POR_PULSE &&
         !low_ev && !pin_low) |=> INTERNAL_RESET_N)
        else $error("data fetch caused reset");

    // Erased vector forces monitor vector
    a_blank_vec: assert property (
        (blank_ev && !POR_PULSE && !low_ev && !pin_low) |=>
        !INTERNAL_RESET_N && s_q.cause[`SRS_C_BLANK] &&
        VECTOR_ADDR == `SRS_VEC_MON)
        else $error("erased vector not handled");

    // Service write clears watchdog and upper counter
    a_wdg_service: assert property (
        (run_st && CPU_EVT.wr_stb &&
         CPU_EVT.addr == `SRS_SERVICE_ADDR) |=>
        s_q.wdg == 8'h00 && s_q.cnt[11:4] == 8'h00)
        else $error("service write ignored");

    // Short recovery takes 32 cycles
    a_short_rec: assert property (
        rec_enter |-> rec_done or
        ##[1:32] !INTERNAL_RESET_N)
        else $error("short stop recovery length wrong");

endmodule : srs_seq

/* rtl/srs_map.svh */
// Offsets, field positions, reset values and counts of the sequencer
// Behaviour
// - Bus clock is oscillator clock divided by four
// - Power-on or low supply: 4096-cycle hold, clocks off
// - Then 64 more cycles of internal reset
// - Stop keeps clocks off until delay; wait stops CPU
// - Every reset fetches user or monitor vector
// - Internal reset returns registers to defaults
// - Internal reset clears counter, sets cause bit
// - Reset pin halts; flag after minimum low time
// - Watchdog reset input passes a two-stage synchroniser
// - Power-on sets its flag, clears the rest
// - Watchdog overflow resets and sets its flag
// - Write to service address clears watchdog, upper counter
// - Counter overflow clocks the watchdog counter
// - Watchdog off only by monitor high-voltage gate
// - Illegal instruction sets flag and resets
// - Stop with stop disabled is illegal opcode
// - Only unmapped opcode fetch causes address reset
// - Erased vectors reset and force monitor mode
// - Enabled low supply resets, holds until recovery
// - Twelve-bit counter supplies watchdog clock
// - Stop clears counter; recovery 32 or 4096
// - Counter runs freely after reset states
// - Stop left by reset uses long recovery
`ifndef SRS_MAP_SVH
`define SRS_MAP_SVH
`define SRS_OFF_CAUSE     8'h00
`define SRS_OFF_CONFIG    8'h04
`define SRS_OFF_STATUS    8'h08
`define SRS_CFG_STOP_EN   0
`define SRS_CFG_SHORT_REC 1
`define SRS_CFG_PWR_DIS   2
`define SRS_CFG_RST_DIS   3
`define SRS_CFG_RESET     4'h0
`define SRS_C_POR         7
`define SRS_C_PIN         6
`define SRS_C_WDG         5
`define SRS_C_BAD_OP      4
`define SRS_C_BAD_ADDR    3
`define SRS_C_BLANK       2
`define SRS_C_LOW_SUP     1
`define SRS_LONG_LAST     12'hFFF
`define SRS_SHORT_LAST    12'h01F
`define SRS_PHASE_LAST    12'h03F
`define SRS_PHASE_LEN     7'h40
`define SRS_VEC_USER      16'hFFFE
`define SRS_VEC_MON       16'hFEFE
`define SRS_SERVICE_ADDR  16'hFFFF
`define SRS_ERASED        8'hFF
`define SRS_PIN_MIN       4'h8
`define SRS_DIV_LAST      2'h3
`define SRS_WDG_LAST      8'hFF
`endif

/* rtl/srs_pkg.sv */
// Types shared by the reset and clock sequencer
package srs_pkg;
    typedef enum logic [2:0] {
        ST_LONG    = 3'b000,
        ST_RUN     = 3'b001,
        ST_HOLD    = 3'b010,
        ST_PHASE   = 3'b011,
        ST_PIN     = 3'b100,
        ST_STOP    = 3'b101,
        ST_STOPREC = 3'b110,
        ST_WAIT    = 3'b111
    } srs_state_t;

    typedef struct packed {
        logic        illegal_op;
        logic        stop_exec;
        logic        wait_exec;
        logic        opc_fetch;
        logic        addr_unmapped;
        logic        vec_fetch;
        logic        wr_stb;
        logic [15:0] addr;
        logic [7:0]  data;
    } srs_cpu_t;

    typedef struct packed {
        srs_state_t  st;
        logic [11:0] cnt;
        logic [1:0]  div;
        logic [7:0]  wdg;
        logic [7:0]  cause;
        logic [3:0]  cfg;
        logic        forced_mon;
        logic        stop_rst;
        logic [3:0]  pin_cnt;
        logic        pin_s1;
        logic        pin_s2;
        logic        wd_s1;
        logic        wd_s2;
        logic        released;
        logic        cpu_en;
        logic        per_en;
        logic        wdg_tick;
        logic [15:0] vec;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } srs_regs_t;
endpackage : srs_pkg

/* sim/srs_partner.sv */
// Far-side model: CPU event strobes and the external reset pin
`timescale 1ns/1ps

module srs_partner
(
    input  logic              clk,
    output srs_pkg::srs_cpu_t cpu_evt,
    output logic              rst_pin_n
);
    srs_pkg::srs_cpu_t req_e  = '0;
    logic              req_v  = 1'b0;
    logic              pin_lo = 1'b0;

    initial cpu_evt = '0;
    initial rst_pin_n = 1'b1;

    // Strobes last one cycle; idle bus lines toggle
    always @(posedge clk)
    begin
        cpu_evt <= req_v ? req_e : {7'h00, ~cpu_evt.addr, ~cpu_evt.data};
    end

    // Pull-up keeps the pin high unless held low
    always @(posedge clk)
    begin
        rst_pin_n <= !pin_lo;
    end

    // One event, applied at the next rising edge
    task automatic send(input srs_pkg::srs_cpu_t e);
        @(negedge clk);
        req_e = e;
        req_v = 1'b1;
        @(negedge clk);
        req_v = 1'b0;
    endtask : send

    // Hold the pin low for n cycles
    task automatic pin_low(input int n);
        @(negedge clk);
        pin_lo = 1'b1;
        repeat (n) @(negedge clk);
        pin_lo = 1'b0;
    endtask : pin_low
endmodule : srs_partner

/* sim/tb.sv */
// Self-checking bench of the reset and clock sequencer
`timescale 1ns/1ps

module tb;
    logic              clk = 1'b0;
    logic              rstn = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [7:0]        paddr = 8'h00;
    logic [31:0]       pwdata = 32'h0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    srs_pkg::srs_cpu_t cpu_evt;
    srs_pkg::srs_cpu_t e;
    logic              wake = 1'b0;
    logic              por = 1'b0;
    logic              low_sup = 1'b0;
    logic              pin_n;
    logic              wdg_in = 1'b0;
    logic              tie0 = 1'b0;
    logic              cpu_en;
    logic              per_en;
    logic              internal_reset_n;
    logic [15:0]       vec;
    logic              mon_f;
    logic              wdg_pls;
    logic [64:0]       q[$];
    logic [64:0]       nt;
    logic [31:0]       rnd = 32'hCA439774;
    int                errors = 0;
    int                n_tests = 0;
    int                k;

    srs_seq srs_seq_inst (.CORE_CLK(clk), .RSTN(rstn), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CPU_EVT(cpu_evt), .WAKE_IRQ(wake), .POR_PULSE(por),
        .LOW_SUPPLY_DET(low_sup), .RST_PIN_N(pin_n), .WDG_RESET_IN(wdg_in),
        .IRQ_HV(tie0), .MONITOR_MODE(tie0), .CPU_CLK_EN(cpu_en),
        .PERIPH_CLK_EN(per_en), .INTERNAL_RESET_N(internal_reset_n),
        .VECTOR_ADDR(vec), .MONITOR_FORCED(mon_f), .WDG_CLK_PULSE(wdg_pls));

    srs_partner srs_partner_inst (.clk(clk), .cpu_evt(cpu_evt),
        .rst_pin_n(pin_n));

    // 250 MHz clock
    initial
    begin
        forever #2 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    task automatic tick;
        @(posedge clk);
    endtask : tick

    task automatic chk(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1)
        begin
            errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : chk

    // APB transfer; expected answer noted for the monitor
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [31:0] x,
                       input logic [31:0] m, input logic err);
        int n;
        q.push_back({err, m, x & m});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        tick();
        penable <= 1'b1;
        n = 0;
        do
        begin
            tick();
            n++;
        end
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        tick();
    endtask : apb

    // Read answers compared with the oldest note
    always @(posedge clk)
    begin
        if (pready === 1'b1)
        begin
            nt = (q.size() > 0) ? q.pop_front() : {1'b1, 64'h0};
            n_tests++;
            if ((prdata & nt[63:32]) !== nt[31:0] || pslverr !== nt[64])
            begin
                errors++;
                $display("wrong value at %0t: read %h", $time, prdata);
            end
        end
    end

    // Number of cycles internal reset stays low
    task automatic rst_len(input int lo, input int hi);
        int n;
        int len;
        n = 0;
        do
        begin
            tick();
            n++;
        end
        while (internal_reset_n === 1'b1 && n < 8);
        len = 0;
        while (internal_reset_n !== 1'b1 && len < 9000)
        begin
            len++;
            tick();
        end
        chk(len >= lo && len <= hi, "reset length");
    endtask : rst_len

    // One reset source, its length and its cause bit
    task automatic hit(input srs_pkg::srs_cpu_t ev, input logic w, ls, p,
                       input logic [7:0] c, input int lo, input int hi);
        if (p)
            fork
                srs_partner_inst.pin_low(12);
            join_none
        wdg_in <= w;
        tick();
        wdg_in <= 1'b0;
        low_sup <= ls;
        if (ls)
            repeat (20) tick();
        low_sup <= 1'b0;
        srs_partner_inst.send(ev);
        rst_len(lo, hi);
        tick();
        apb(1'b0, 8'h00, 32'h0, {24'h0, c}, 32'hFF, 1'b0);
    endtask : hit

    task automatic summarize;
        $display("errors=%0d comparisons=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    // Watchdog against a hang
    initial
    begin
        repeat (30000) tick();
        errors++;
        $display("wrong value at %0t: timeout", $time);
        summarize();
    end

    // Main sequence
    initial
    begin
        repeat (6) tick();
        rstn <= 1'b1;
        por <= 1'b1;
        tick();
        por <= 1'b0;
        rst_len(4160, 4170);
        chk(vec === 16'hFFFE, "user vector");
        apb(1'b0, 8'h00, 32'h0, 32'h80, 32'hFF, 1'b0);
        k = 0;
        repeat (40)
        begin
            tick();
            k += (cpu_en === 1'b1);
        end
        chk(k == 10, "bus clock rate");
        rnd = lfsr(rnd);
        apb(1'b1, 8'h0C, rnd, 32'h0, 32'h0, 1'b1);
        apb(1'b0, 8'h0C, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1);
        apb(1'b1, 8'h04, {rnd[31:4], 4'h6}, 32'h0, 32'h0, 1'b0);
        apb(1'b0, 8'h04, 32'h0, 32'h6, 32'hF, 1'b0);
        e = '0;
        e.illegal_op = 1'b1;
        hit(e, 1'b0, 1'b0, 1'b0, 8'h10, 64, 64);
        apb(1'b0, 8'h04, 32'h0, 32'h0, 32'hF, 1'b0);
        e = '0;
        e.stop_exec = 1'b1;
        hit(e, 1'b0, 1'b0, 1'b0, 8'h10, 64, 64);
        e = '0;
        e.opc_fetch = 1'b1;
        e.addr_unmapped = 1'b1;
        hit(e, 1'b0, 1'b0, 1'b0, 8'h08, 64, 64);
        e.opc_fetch = 1'b0;
        tie0 <= 1'b1;
        wdg_in <= 1'b1;
        srs_partner_inst.send(e);
        tick();
        wdg_in <= 1'b0;
        k = 0;
        repeat (8)
        begin
            tick();
            k += (internal_reset_n !== 1'b1);
        end
        tie0 <= 1'b0;
        chk(k == 0, "data fetch or gated watchdog reset");
        apb(1'b0, 8'h00, 32'h0, 32'h0, 32'hFF, 1'b0);
        hit('0, 1'b1, 1'b0, 1'b0, 8'h20, 64, 64);
        apb(1'b1, 8'h04, {rnd[31:4], 4'h3}, 32'h0, 32'h0, 1'b0);
        e = '0;
        e.stop_exec = 1'b1;
        srs_partner_inst.send(e);
        repeat (4) tick();
        k = 0;
        repeat (40)
        begin
            tick();
            k += (cpu_en === 1'b1 || per_en === 1'b1);
        end
        chk(k == 0, "clocks in stop");
        wake <= 1'b1;
        k = 0;
        do
        begin
            tick();
            k++;
        end
        while (cpu_en !== 1'b1 && k < 100);
        wake <= 1'b0;
        chk(k >= 33 && k <= 40, "short recovery");
        rnd = lfsr(rnd);
        e = '0;
        e.wr_stb = 1'b1;
        e.addr = 16'hFFFF;
        e.data = rnd[7:0];
        srs_partner_inst.send(e);
        tick();
        apb(1'b0, 8'h08, 32'h0, 32'h0, 32'h00FFFE00, 1'b0);
        hit('0, 1'b0, 1'b0, 1'b1, 8'h40, 74, 84);
        hit('0, 1'b0, 1'b1, 1'b0, 8'h02, 4158, 4175);
        e = '0;
        e.vec_fetch = 1'b1;
        e.data = 8'hFF;
        hit(e, 1'b0, 1'b0, 1'b0, 8'h04, 64, 64);
        chk(mon_f === 1'b1 && vec === 16'hFEFE, "monitor vector");
        summarize();
    end
endmodule : tb
